// ===== core/adc_seq_defs.vh
// register offsets, field positions, reset values and timing counts for the converter control
// Contract
// - clearing enable aborts and clears all flags
// - irq enable gates end-of-sequence interrupt
// - channel codes 0-11 valid, 11XX reserved
// - scan and repeat writes ignored while started
// - repeat mode loops cycle, else stops
// - scan 00 single, 01 four channels
// - start self-clears only when not repeating
// - divide codes give 1 to 32
// - delay codes give 1 to 64 clocks
// - powerdown on reset, or when disabled with the power bit set
// - results fill slots zero to three
// - result is 8-bit linear code
// - result slots need no reset value
// - control bits reset to zero
// - reading any slot clears pending interrupt
// - conversion takes ten converter clocks
// - done set on last store of a cycle, cleared on slot read
// - overwrite full slot sets sticky overrun flag
// - index loads 11 on start, increments
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
`define OFF_ENABLE   8'h00
`define OFF_MODE     8'h04
`define OFF_TIMING   8'h08
`define OFF_STATUS   8'h0C
`define OFF_SLOT0    8'h10
`define OFF_SLOT1    8'h14
`define OFF_SLOT2    8'h18
`define OFF_SLOT3    8'h1C
`define EN_BIT       0
`define IRQEN_BIT    2
`define START_BIT    7
`define SCAN_LSB     5
`define REPEAT_BIT   4
`define CHAN_LSB     0
`define DIV_LSB      0
`define DELAY_LSB    3
`define PWR_BIT      6
`define ST_DONE      0
`define ST_BUSY      1
`define ST_OVR       2
`define ST_IDX_LSB   4
`define CTRL_RESET   8'h00
`define ENABLE_MASK  8'h05
`define TIMING_MASK  8'h7F
`define CONV_CLOCKS  4'hA
`define DIV_MAX_CODE   3'h5
`define DELAY_MAX_CODE 3'h6
`define IDX_START      2'h3
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// ===== core/adc_sequencer_control.v
// converter control: registers, clock enable, sequencer and result slots
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"
module adc_sequencer_control #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // axi4-lite write address and data
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  // axi4-lite read
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // analog core
  output reg  [3:0]        anChannel,
  output reg               anSample,
  output reg               anPowerDown,
  output reg               convIrq,
  input  wire [7:0]        anResult
);
  localparam S_IDLE = 2'b00;
  localparam S_DELAY = 2'b01;
  localparam S_CONV = 2'b10;

  // exponent code to count, shared by divider and delay
  function [6:0] pow2;
    input [2:0] code;
    begin
      pow2 = 7'h01 << code;
    end
  endfunction

  // reserved codes fold onto the slowest legal setting, so a stray write
  // cannot zero a count and leave the sequencer racing or wrapping
  function [6:0] clampPow2;
    input [2:0] code;
    input [2:0] maxCode;
    begin
      if (code > maxCode)
        clampPow2 = pow2(maxCode);
      else
        clampPow2 = pow2(code);
    end
  endfunction

  // register word match, shared by every write strobe
  function regHit;
    input [ADDR_W-1:0] addr;
    input [7:0]        offset;
    begin
      regHit = (addr == offset);
    end
  endfunction

  reg  [7:0] enableCtl_q, modeCtl_q, timingCtl_q;
  reg  [7:0] slot_q [0:3];
  reg  [3:0] slotFull_q;
  reg        done_q, ovr_q;
  reg  [1:0] lastIdx_q;
  reg  [1:0] state_q;
  reg  [6:0] pre_q, cnt_q;
  reg  [1:0] step_q;
  reg        tick_q;
  reg  [2:0] pinA_q, pinB_q;
  reg  [7:0] resA_q, resB_q;
  reg  [ADDR_W-1:0] awAddr_q;
  reg        awHave_q, wHave_q;
  reg  [31:0] wData_q;
  reg  [3:0] wStrb_q;

  wire enabled  = enableCtl_q[`EN_BIT];
  wire started  = modeCtl_q[`START_BIT];
  wire scanMode = (modeCtl_q[`SCAN_LSB+1:`SCAN_LSB] == 2'b01);
  wire repeatOn = modeCtl_q[`REPEAT_BIT];
  wire doWrite  = awHave_q && wHave_q && !bvalid;
  wire doRead   = arvalid && arready;
  wire [ADDR_W-1:0] rAddr = araddr;
  wire readsSlot = doRead && (rAddr[7:4] == 4'h1) && (rAddr[1:0] == 2'b00);
  wire wLow = wStrb_q[0];
  // register strobes, taken once both write halves are in
  wire wEn  = doWrite && wLow && regHit(awAddr_q, `OFF_ENABLE);
  wire wMode = doWrite && wLow && regHit(awAddr_q, `OFF_MODE);
  wire wTim = doWrite && wLow && regHit(awAddr_q, `OFF_TIMING);
  wire wStat = doWrite && wLow && regHit(awAddr_q, `OFF_STATUS);

  // sequencing decodes
  wire convEnd = (state_q == S_CONV) && tick_q && (cnt_q == 7'h01);
  // a cycle is four stores when scanning or repeating, else one
  wire fourStep = scanMode || repeatOn;
  wire lastStep = !fourStep || (step_q == 2'b11);
  // a repeating single-channel cycle ends early once software drops start
  wire stopNow  = scanMode ? (lastStep && (!repeatOn || !started))
                           : (!repeatOn || !started);
  wire seqEnd   = convEnd && (lastStep || stopNow);

  // tick period in system clocks, sample delay in converter clocks
  wire [6:0] divCount   = clampPow2(timingCtl_q[`DIV_LSB+2:`DIV_LSB], `DIV_MAX_CODE);
  wire [6:0] delayCount = clampPow2(timingCtl_q[`DELAY_LSB+2:`DELAY_LSB], `DELAY_MAX_CODE);
  wire [1:0] nextIdx = lastIdx_q + 2'b01;
  wire startRise = wMode && wData_q[`START_BIT] && !started;

  ////////////////////////////////////////////////////////////////
  // write channel capture; address and data taken in either order
  always @(posedge clk) begin
    if (rst) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= {ADDR_W{1'b0}};
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_q <= awaddr;
        awHave_q <= 1'b1;
        awready  <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wHave_q <= 1'b1;
        wready  <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= (awAddr_q[7:5] == 3'b000 && awAddr_q[1:0] == 2'b00) ?
                  `RESP_OKAY : `RESP_SLVERR;
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read channel; one read outstanding, arready drops until rready
  always @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (doRead) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `RESP_OKAY;
        case (rAddr)
          `OFF_ENABLE: rdata <= {24'h000000, enableCtl_q};
          `OFF_MODE:   rdata <= {24'h000000, modeCtl_q};
          `OFF_TIMING: rdata <= {24'h000000, timingCtl_q};
          `OFF_STATUS: rdata <= {24'h000000, 2'b00, lastIdx_q, 1'b0, ovr_q,
                                 (state_q != S_IDLE), done_q};
          `OFF_SLOT0:  rdata <= {24'h000000, slot_q[0]};
          `OFF_SLOT1:  rdata <= {24'h000000, slot_q[1]};
          `OFF_SLOT2:  rdata <= {24'h000000, slot_q[2]};
          `OFF_SLOT3:  rdata <= {24'h000000, slot_q[3]};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // control registers; reserved bits kept at zero
  always @(posedge clk) begin
    if (rst) begin
      enableCtl_q <= `CTRL_RESET;
      modeCtl_q   <= `CTRL_RESET;
      timingCtl_q <= `CTRL_RESET;
    end else begin
      if (wEn)
        enableCtl_q <= wData_q[7:0] & `ENABLE_MASK;
      if (wTim)
        timingCtl_q <= wData_q[7:0] & `TIMING_MASK;
      // mode fields take writes even while off, so setup can precede enable
      if (wMode) begin
        modeCtl_q[3:0] <= wData_q[3:0];
        if (!started)  // scan and repeat bits frozen once started
          modeCtl_q[6:4] <= wData_q[6:4];
      end
      // start: disable beats software, software beats the hardware clear
      if (!enabled || (wEn && !wData_q[`EN_BIT])) begin
        modeCtl_q[`START_BIT] <= 1'b0;
      end else if (wMode) begin
        modeCtl_q[`START_BIT] <= wData_q[`START_BIT];
      end else if (convEnd && stopNow && !repeatOn) begin
        modeCtl_q[`START_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // converter clock as a one-cycle enable from a prescaler
  always @(posedge clk) begin
    if (rst || !enabled) begin
      pre_q  <= 7'h00;
      tick_q <= 1'b0;
    end else if (pre_q + 7'h01 >= divCount) begin
      pre_q  <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencer: sample delay, ten clocks of conversion, next step
  always @(posedge clk) begin
    if (rst || !enabled) begin
      state_q <= S_IDLE;  // abort in progress
      cnt_q   <= 7'h00;
      step_q  <= 2'b00;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (startRise) begin
            state_q <= S_DELAY;
            step_q  <= 2'b00;
            cnt_q   <= delayCount;
          end
        end
        S_DELAY: begin
          if (tick_q) begin
            if (cnt_q == 7'h01) begin
              state_q <= S_CONV;
              cnt_q   <= {3'b000, `CONV_CLOCKS};
            end else begin
              cnt_q <= cnt_q - 7'h01;
            end
          end
        end
        S_CONV: begin
          if (tick_q) begin
            if (cnt_q == 7'h01) begin
              // software clearing start stops after this conversion or scan
              if (stopNow) begin
                state_q <= S_IDLE;
              end else begin
                state_q <= S_DELAY;
                cnt_q   <= delayCount;
              end
              step_q <= fourStep ? step_q + 2'b01 : 2'b00;
            end else begin
              cnt_q <= cnt_q - 7'h01;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // analog result passes two flops before it is stored
  always @(posedge clk) begin
    resA_q <= anResult;
    resB_q <= resA_q;
  end

  // result slots hold no reset value
  always @(posedge clk) begin
    if (enabled && convEnd)
      slot_q[nextIdx] <= resB_q;  // 8-bit linear code
  end

  ////////////////////////////////////////////////////////////////
  // status flags; a new store beats a same-cycle read or write-one clear, but a disable clears over it
  always @(posedge clk) begin
    if (rst || !enabled || (wEn && !wData_q[`EN_BIT])) begin
      done_q     <= 1'b0;
      ovr_q      <= 1'b0;
      slotFull_q <= 4'h0;
      lastIdx_q  <= `IDX_START;
    end else begin
      if (startRise)
        lastIdx_q <= `IDX_START;
      if (readsSlot)
        slotFull_q[rAddr[3:2]] <= 1'b0;
      if (readsSlot)
        done_q <= 1'b0;
      if (wStat && wData_q[`ST_OVR])
        ovr_q <= 1'b0;  // write one clears
      if (convEnd) begin
        lastIdx_q <= nextIdx;
        slotFull_q[nextIdx] <= 1'b1;
        if (slotFull_q[nextIdx])
          ovr_q <= 1'b1;
        if (lastStep || stopNow)
          done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // analog-side controls and the interrupt line
  always @(posedge clk) begin
    if (rst) begin
      anChannel   <= 4'h0;
      anSample    <= 1'b0;
      anPowerDown <= 1'b1;
      convIrq     <= 1'b0;
    end else begin
      anChannel <= modeCtl_q[3:0] + (scanMode ? {2'b00, step_q} : 4'h0);
      anSample  <= (state_q == S_DELAY);
      anPowerDown <= timingCtl_q[`PWR_BIT] && !enabled;
      if (!enabled || readsSlot)
        convIrq <= 1'b0;
      else if (seqEnd && enableCtl_q[`IRQEN_BIT])
        convIrq <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== test/adc_seq_checker_assertions.sv
// port checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"
module adc_seq_checker #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // bus
  input wire logic              awready,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  // analog core
  input wire logic [3:0]        anChannel,
  input wire logic              anSample,
  input wire logic              anPowerDown,
  input wire logic              convIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // bus handshake
  property p_rdAnswer; arvalid && arready |=> rvalid; endproperty
  a_rdAnswer: assert property (p_rdAnswer) else $error("read answer late");
  property p_rdBusy; rvalid |-> !arready; endproperty
  a_rdBusy: assert property (p_rdBusy) else $error("read taken while answering");
  property p_wrBusy; bvalid |-> !awready && !wready; endproperty
  a_wrBusy: assert property (p_wrBusy) else $error("write taken while answering");
  // holes in the map answer with an error, words in it without
  property p_slvErr; arvalid && arready && araddr > 8'h1C |=> rresp == `RESP_SLVERR;
  endproperty
  a_slvErr: assert property (p_slvErr) else $error("unmapped read not refused");
  property p_okay;
    arvalid && arready && araddr <= 8'h1C && araddr[1:0] == 2'h0 |=> rresp == `RESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("mapped read refused");
  //////////////////////////////////////////////////////////////////////////////
  // sequencing; irq clears within two edges of a slot read
  property p_irqClr;
    arvalid && arready && araddr >= `OFF_SLOT0 && araddr <= `OFF_SLOT3 |-> ##[1:2] !convIrq;
  endproperty
  a_irqClr: assert property (p_irqClr) else $error("irq kept after slot read");
  // one cycle of grace: anSample falls one edge after anPowerDown rises on disable
  property p_pdIdle; anPowerDown && $past(anPowerDown) |-> !anSample; endproperty
  a_pdIdle: assert property (p_pdIdle) else $error("sampling while down");
  property p_chanHold; anSample && $past(anSample) |-> $stable(anChannel); endproperty
  a_chanHold: assert property (p_chanHold) else $error("channel moved");
endmodule
bind adc_sequencer_control adc_seq_checker #(.ADDR_W(ADDR_W)) i_chk (.clk, .rst, .awready,
  .wready, .bvalid, .araddr, .arvalid, .arready, .rresp, .rvalid, .anChannel, .anSample,
  .anPowerDown, .convIrq);
`default_nettype wire

// ===== test/analog_core_model.sv
// behavioural analog sampling core facing the converter control
`timescale 1ns/10ps
`default_nettype none
module analog_core_model (
  // clock
  input wire logic       clk,
  // control
  input wire logic [3:0] anChannel,
  input wire logic       anPowerDown,
  // result
  output var logic [7:0] anResult
);
  logic [7:0] junk;
  initial junk = 8'h00;
  // powered down the core gives a moving pattern, never a held code
  always @(posedge clk) begin
    junk <= junk + 8'h5B;
  end
  // linear code per input: each channel sits at its own level
  always @* begin
    anResult = anPowerDown ? junk : {anChannel, ~anChannel};
  end
endmodule
`default_nettype wire

// ===== test/tb_adc_sequencer_control.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.vh"
module tb_adc_sequencer_control;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, anSample, anPowerDown, convIrq;
  logic [7:0]  awaddr, araddr, anResult;
  logic [3:0]  wstrb, anChannel;
  logic [1:0]  bresp, rresp, rr, wr;
  logic [31:0] wdata, rdata, rd;
  int          mismatches, n_checks;
  adc_sequencer_control #(.ADDR_W(8)) i_dut (.clk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .anChannel, .anSample, .anPowerDown,
    .convIrq, .anResult);
  analog_core_model i_core (.clk, .anChannel, .anPowerDown, .anResult);
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp8(input logic [3:0] c);
    return {c, ~c};
  endfunction
  task automatic chk(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ready lines stay high, so each answer is taken at the edge it shows
  // no cycle count is assumed: only the hang guard ends a wait
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
  endtask
  task automatic waitIrq;
    repeat (2000) if (convIrq !== 1'b1) @(posedge clk);
    chk("irq", convIrq, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      axr(8'(i * 4));
      chk("ctrl", rd[7:0], 8'h00);
    end
    axr(`OFF_STATUS);
    chk("flags", rd[2:0], 3'h0);
    chk("pwrdn", anPowerDown, 1'b0);
    axr(8'h40);
    chk("resp", rr, `RESP_SLVERR);
    axw(8'h40, 32'h00);
    chk("bresp", wr, `RESP_SLVERR);
    // divide by 32 keeps the converter clock under its ceiling, set while off
    axw(`OFF_TIMING, 32'h45);
    chk("bresp", wr, `RESP_OKAY);
    // the pin follows the register one edge later
    @(posedge clk);
    chk("pwrdn", anPowerDown, 1'b1);
    axw(`OFF_ENABLE, 32'h05);
    @(posedge clk);
    chk("pwrdn", anPowerDown, 1'b0);
    repeat (1500) @(posedge clk);
    $display("reset test done");
  endtask
  task automatic t_single;
    axw(`OFF_MODE, 32'h83);
    repeat (50) if (anSample !== 1'b1) @(posedge clk);
    chk("sample", anSample, 1'b1);
    chk("chan", anChannel, 4'h3);
    axr(`OFF_STATUS);
    chk("busy", rd[1], 1'b1);
    waitIrq();
    axr(`OFF_MODE);
    chk("start", rd[7], 1'b0);
    axr(`OFF_STATUS);
    chk("done", rd[0], 1'b1);
    chk("index", rd[5:4], 2'h0);
    axr(`OFF_SLOT0);
    chk("slot0", rd[7:0], exp8(4'h3));
    axr(`OFF_STATUS);
    chk("done", rd[0], 1'b0);
    chk("irq", convIrq, 1'b0);
    $display("single test done");
  endtask
  task automatic t_scan;
    axw(`OFF_MODE, 32'hA4);
    waitIrq();
    axr(`OFF_STATUS);
    chk("idx", rd[5:4], 2'h3);
    chk("ovr", rd[2], 1'b0);
    for (int i = 0; i < 4; i++) begin
      axr(8'(`OFF_SLOT0 + i * 4));
      chk("slot", rd[7:0], exp8(4'(4 + i)));
    end
    axr(`OFF_MODE);
    chk("start", rd[7], 1'b0);
    $display("scan test done");
  endtask
  task automatic t_repeat;
    int n;
    axw(`OFF_MODE, 32'h90);
    axw(`OFF_MODE, 32'hB0);
    axr(`OFF_MODE);
    chk("scan", rd[7:4], 4'h9);
    waitIrq();
    // one repeating channel signals only once all four slots are filled
    axr(`OFF_STATUS);
    chk("idx", rd[5:4], 2'h3);
    chk("done", rd[0], 1'b1);
    n = 0;
    do begin
      axr(`OFF_STATUS);
      n++;
    end while (rd[2] !== 1'b1 && n < 1000);
    chk("ovr", rd[2], 1'b1);
    axr(`OFF_MODE);
    chk("start", rd[7], 1'b1);
    axr(`OFF_SLOT1);
    chk("slot1", rd[7:0], exp8(4'h0));
    axw(`OFF_ENABLE, 32'h04);
    axr(`OFF_STATUS);
    chk("flags", rd[2:0], 3'h0);
    axr(`OFF_MODE);
    chk("start", rd[7], 1'b0);
    chk("pwrdn", anPowerDown, 1'b1);
    chk("irq", convIrq, 1'b0);
    $display("repeat test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb} = 6'h3F;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_repeat();
    close_out();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
